// [logic/pw_consts.svh]
// constants for the parallel word input port
//
// Function
// R1 - the port answers an eight-word window whose start moves up by eight words per base-switch step.
// R2 - base-switch bits meet the address bits through per-bit selectable inversion gates.
// R3 - with address bit two low the access goes to the input chip and bits one and zero pick the location.
// R4 - with address bit two high a read returns configuration switch contents, one selection per bit pair.
// R5 - each switch selector takes one bit of each of the four switches and bits one and zero pick it.
// R6 - the source raises data valid from low to high once a stable word stands on the sixteen lines.
// R7 - after the processor has read the word the port drives data accepted from high to low; with early ack set the port drops it on capture instead.
// R8 - format settings other than the two binary ones read the word as four decimal digits.
// R9 - format setting eight reads the word as a fifteen-bit magnitude with a separate sign.
// R10 - in sign and magnitude form the top bit is the sign, one negative and zero positive.
// R11 - format setting nine reads the word as a sixteen-bit two's complement value.
// R12 - a source may tie data accepted to data valid and then accept glitches from changing data.
// R13 - the base setting fixes the channel number, 257 at setting zero up to 272 at setting fifteen.
// R14 - decimal digits are taken in nibbles with bits fifteen to twelve as the highest digit.
// R15 - data accepted returns high once the source drops data valid low.
// R16 - the low byte of the word sits at the lower data location and the high byte at the next one.
`ifndef PW_CONSTS_SVH
`define PW_CONSTS_SVH

// word index of the window at base setting zero; byte address is four times it
`define PW_WIN_BASE   16'h8380
`define PW_LOC_LO     3'h0
`define PW_LOC_HI     3'h1
`define PW_LOC_DEC    3'h2
`define PW_LOC_STAT   3'h3
`define PW_FMT_SM     4'h8
`define PW_FMT_2C     4'h9
`define PW_CHAN_BASE  9'h101
`define PW_CTRL_RST   1'b0
`define PW_WORD_W     16
`define PW_FIFO_DEPTH 16
`define PW_STAT_CHAN  16
`define PW_STAT_LVL   3

`endif

// [logic/pw_pkg.sv]
// types shared by the parallel word input port
package pw_pkg;

  typedef enum logic [1:0] {
    hs_idle  = 2'b00,
    hs_held  = 2'b01,
    hs_acked = 2'b10
  } hs_state_t;

  typedef struct packed {
    logic       hit;
    logic       wr;
    logic [2:0] loc;
  } acc_t;

  typedef struct packed {
    logic [3:0] fmt;
    logic [3:0] c;
    logic [3:0] b;
    logic [3:0] a;
  } cfg_sw_t;

endpackage

// [logic/parallel_word_input_port.sv]
// parallel word input port: bus slave, handshake, word fifo and number decoding
`timescale 1ns/100ps
`include "pw_consts.svh"

module pw_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 in_valid,
  output logic                      in_ready,
  input  wire logic [W-1:0]         in_data,
  output logic                      out_valid,
  input  wire logic                 out_ready,
  output logic [W-1:0]              out_data,
  output logic [$clog2(D):0]        level
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] full_lv = (AW+1)'(D);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0]   cnt_ff;
  logic [AW-1:0] nxt_wp;
  logic [AW-1:0] nxt_rp;
  logic [AW:0]   nxt_cnt;
  logic          do_push;
  logic          do_pop;

  assign in_ready  = cnt_ff != full_lv;
  assign out_valid = cnt_ff != '0;
  assign out_data  = mem[rp_ff];
  assign level     = cnt_ff;
  assign do_push   = in_valid & in_ready;
  assign do_pop    = out_valid & out_ready;

  always_comb begin
    nxt_wp  = do_push ? wp_ff + 1'b1 : wp_ff;
    nxt_rp  = do_pop ? rp_ff + 1'b1 : rp_ff;
    nxt_cnt = cnt_ff;
    if (do_push && !do_pop) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (do_pop && !do_push) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wp_ff  <= nxt_wp;
      rp_ff  <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

  // storage has no reset; an empty fifo never exposes it as valid
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wp_ff] <= in_data;
    end
  end
endmodule

module parallel_word_input_port import pw_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [15:0] external_word_lines,
  input  wire logic        data_valid_in,
  output logic             data_accepted_out,
  input  wire logic [3:0]  base_address_switch,
  input  wire logic [3:0]  config_switch_a,
  input  wire logic [3:0]  config_switch_b,
  input  wire logic [3:0]  config_switch_c,
  input  wire logic [3:0]  number_format_switch
);
  localparam int W  = `PW_WORD_W;
  localparam int D  = `PW_FIFO_DEPTH;
  localparam int LW = $clog2(D) + 1;
  localparam logic [15:0] win_base = `PW_WIN_BASE;

  cfg_sw_t      sw;
  acc_t         acc;
  acc_t         acc_ff;
  acc_t         nxt_acc;
  hs_state_t    hs_ff;
  hs_state_t    nxt_hs;
  logic [15:0]  idx;
  logic [3:0]   base_gates;
  logic         take;
  logic         pop;
  logic         early_ack_ff;
  logic         nxt_early_ack;
  logic [31:0]  hrdata_ff;
  logic [31:0]  nxt_hrdata;
  logic         in_valid;
  logic         in_ready;
  logic         out_valid;
  logic [W-1:0] head;
  logic [LW-1:0] level;
  logic [8:0]   chan;
  logic [31:0]  decoded;
  logic [31:0]  status;

  assign sw = '{fmt: number_format_switch, c: config_switch_c,
                b: config_switch_b, a: config_switch_a};

  // address phase decode; zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;
  assign take      = hsel & hready & htrans[1];
  assign idx       = haddr[17:2];
  // the base index has zero in bits 6:3, so each switch step adds eight words
  assign base_gates = ~(idx[6:3] ^ base_address_switch); // R2
  assign acc.hit = take && (haddr[31:18] == '0) && (haddr[1:0] == 2'b00)
                   && (idx[15:7] == win_base[15:7]) && (&base_gates); // R1
  assign acc.wr  = hwrite;
  assign acc.loc = idx[2:0];

  // reading the high byte retires the word, so software reads low byte first
  assign pop = acc.hit & !hwrite & (acc.loc == `PW_LOC_HI) & out_valid; // R3 R16

  assign chan = `PW_CHAN_BASE + {5'h0, base_address_switch}; // R13

  function automatic logic [31:0] decode_word(input logic [15:0] w, input logic [3:0] f);
    logic [31:0] mag;
    logic [15:0] bcd;
    mag = {17'h0, w[14:0]};
    // nibbles above nine are not rejected; the sum just reflects them
    bcd = {12'h0, w[15:12]} * 16'd1000 + {12'h0, w[11:8]} * 16'd100
        + {12'h0, w[7:4]} * 16'd10 + {12'h0, w[3:0]}; // R14
    case (f)
      `PW_FMT_SM: decode_word = w[15] ? 32'h0 - mag : mag; // R9 R10
      `PW_FMT_2C: decode_word = {{16{w[15]}}, w}; // R11
      default:    decode_word = {16'h0, bcd}; // R8
    endcase
  endfunction

  assign decoded = decode_word(head, sw.fmt);
  assign status  = {7'h0, chan, 6'h0, data_accepted_out, data_valid_in,
                    level, !in_ready, !out_valid, early_ack_ff};

  always_comb begin
    nxt_hrdata = 32'h0;
    if (acc.hit && !hwrite) begin
      if (acc.loc[2]) begin
        nxt_hrdata[3:0] = {sw.fmt[acc.loc[1:0]], sw.c[acc.loc[1:0]],
                           sw.b[acc.loc[1:0]], sw.a[acc.loc[1:0]]}; // R4 R5
      end else begin
        case (acc.loc)
          `PW_LOC_LO:  nxt_hrdata[7:0] = out_valid ? head[7:0] : 8'h0; // R16
          `PW_LOC_HI:  nxt_hrdata[7:0] = out_valid ? head[15:8] : 8'h0; // R16
          `PW_LOC_DEC: nxt_hrdata = out_valid ? decoded : 32'h0;
          `PW_LOC_STAT: nxt_hrdata = status;
          default:     nxt_hrdata = 32'h0;
        endcase
      end
    end
  end

  // data phase write: only the status location takes data, bit 0 is early ack
  always_comb begin
    nxt_acc       = take ? acc : '0;
    nxt_early_ack = early_ack_ff;
    if (acc_ff.hit && acc_ff.wr && acc_ff.loc == `PW_LOC_STAT) begin
      nxt_early_ack = hwdata[0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_ff       <= '0;
      hrdata_ff    <= 32'h0;
      early_ack_ff <= `PW_CTRL_RST;
    end else begin
      acc_ff       <= nxt_acc;
      hrdata_ff    <= nxt_hrdata;
      early_ack_ff <= nxt_early_ack;
    end
  end

  // handshake: a full fifo holds the source off, since accepted stays high
  assign in_valid = (hs_ff == hs_idle) & data_valid_in; // R6
  assign data_accepted_out = hs_ff != hs_acked;

  always_comb begin
    nxt_hs = hs_ff;
    case (hs_ff)
      hs_idle: begin
        if (in_valid && in_ready) begin
          nxt_hs = early_ack_ff ? hs_acked : hs_held;
        end
      end
      hs_held: begin
        if (!data_valid_in) begin
          nxt_hs = hs_idle;
        end else if (pop || early_ack_ff) begin
          nxt_hs = hs_acked; // R7
        end
      end
      hs_acked: begin
        if (!data_valid_in) begin
          nxt_hs = hs_idle; // R15
        end
      end
      default: nxt_hs = hs_idle;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hs_ff <= hs_idle;
    end else begin
      hs_ff <= nxt_hs;
    end
  end

  pw_fifo #(
    .W (W),
    .D (D)
  ) word_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   (external_word_lines),
    .out_valid (out_valid),
    .out_ready (pop),
    .out_data  (head),
    .level     (level)
  );

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence word_taken;
    hs_ff == hs_idle && data_valid_in && in_ready;
  endsequence

  sequence word_read;
    hs_ff == hs_held && data_valid_in && pop;
  endsequence

  sequence read_at(logic [2:0] l);
    acc.hit && !hwrite && acc.loc == l;
  endsequence

  window_hit_a: assert property ( // R1
    take && haddr[31:18] == '0 && haddr[1:0] == 2'b00
    && idx == win_base + {9'h0, base_address_switch, 3'h0} |-> acc.hit)
    else $error("window address not decoded");

  window_miss_a: assert property ( // R2
    acc.hit |-> idx[6:3] == base_address_switch)
    else $error("window decoded at wrong base");

  switch_read_a: assert property ( // R4
    read_at({1'b1, 2'b10}) |=> hrdata == {28'h0, $past(sw.fmt[2]), $past(sw.c[2]),
                                          $past(sw.b[2]), $past(sw.a[2])})
    else $error("switch selector returned wrong bits");

  low_byte_a: assert property ( // R16
    read_at(`PW_LOC_LO) and out_valid |=> hrdata == {24'h0, $past(head[7:0])})
    else $error("low byte location wrong");

  accept_drop_a: assert property ( // R7
    word_read |=> !data_accepted_out)
    else $error("accepted not dropped after read");

  accept_hold_a: assert property ( // R7
    word_taken ##1 (hs_ff == hs_held && data_valid_in && !pop && !early_ack_ff)
    |=> data_accepted_out)
    else $error("accepted dropped before read");

  accept_rise_a: assert property ( // R15
    !data_accepted_out && !data_valid_in |=> data_accepted_out)
    else $error("accepted not returned high");

  push_word_a: assert property ( // R6
    word_taken and !pop |=> level == $past(level) + 1'b1)
    else $error("valid word not captured");

  sign_mag_a: assert property ( // R10
    out_valid && sw.fmt == `PW_FMT_SM |->
    decoded == (head[15] ? 32'h0 - {17'h0, head[14:0]} : {17'h0, head[14:0]}))
    else $error("sign magnitude decode wrong");

  twos_comp_a: assert property ( // R11
    out_valid && sw.fmt == `PW_FMT_2C |-> $signed(decoded) == $signed(head))
    else $error("two's complement decode wrong");

  bcd_form_a: assert property ( // R8
    out_valid && sw.fmt != `PW_FMT_SM && sw.fmt != `PW_FMT_2C
    && head == 16'h1234 |-> decoded == 32'd1234)
    else $error("decimal decode wrong");

  channel_a: assert property ( // R13
    read_at(`PW_LOC_STAT) |=> hrdata[24:16] == 9'd257 + {5'h0, $past(base_address_switch)})
    else $error("channel number wrong");

endmodule

// [sim/word_source.sv]
// behavioural external source driving words over the valid/accepted handshake
`timescale 1ns/100ps
module word_source (
  input  wire logic   clk,
  input  wire logic   data_accepted_out,
  output logic [15:0] external_word_lines,
  output logic        data_valid_in
);
  initial begin
    external_word_lines = 16'h0000;
    data_valid_in       = 1'b0;
  end

  // word settles one cycle before valid rises
  task automatic present(input logic [15:0] w);
    external_word_lines <= w;
    @(posedge clk);
    data_valid_in <= 1'b1;
  endtask

  // ok is low when the word was never accepted; hold stalls the release
  task automatic finish(input int hold, output logic ok);
    int n;
    n = 0;
    while (data_accepted_out !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    ok = (data_accepted_out === 1'b0);
    repeat (hold) @(posedge clk);
    data_valid_in <= 1'b0;
    // undriven lines must not keep showing the old word
    external_word_lines <= ~external_word_lines;
    repeat (3) @(posedge clk);
  endtask

  // accepted wired back to valid; the copy is taken each clock, so valid lags accepted by one cycle
  task automatic tied(input logic [15:0] w, input int n);
    external_word_lines <= w;
    repeat (n) begin
      @(posedge clk);
      data_valid_in <= data_accepted_out;
    end
    @(posedge clk);
    data_valid_in <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
endmodule

// [sim/parallel_word_input_port_tb.sv]
// self-checking bench for the parallel word input port
`timescale 1ns/100ps
module parallel_word_input_port_tb import pw_pkg::*;;
  logic        clk;
  logic        rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [15:0] ewl;
  logic        dvi;
  logic        dao;
  logic [3:0]  base;
  cfg_sw_t     cfg;
  logic [15:0] lf = 16'h0002;
  logic [15:0] w;
  logic [15:0] wq [16];
  logic [31:0] d;
  logic [3:0]  f;
  logic        ok;
  int          errors = 0;
  int          n_tests = 0;

  parallel_word_input_port DUT (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .external_word_lines(ewl), .data_valid_in(dvi),
    .data_accepted_out(dao), .base_address_switch(base), .config_switch_a(cfg.a),
    .config_switch_b(cfg.b), .config_switch_c(cfg.c), .number_format_switch(cfg.fmt));
  word_source src (.clk(clk), .data_accepted_out(dao), .external_word_lines(ewl), .data_valid_in(dvi));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction

  function automatic logic [31:0] adr(input logic [2:0] l);
    return 32'h20e00 + {23'h0, base, 5'h00} + {27'h0, l, 2'b00};
  endfunction

  function automatic logic [31:0] dec(input logic [15:0] v, input logic [3:0] m);
    if (m == 4'h8) return v[15] ? -{17'h0, v[14:0]} : {17'h0, v[14:0]};
    if (m == 4'h9) return {{16{v[15]}}, v};
    return v[15:12] * 1000 + v[11:8] * 100 + v[7:4] * 10 + v[3:0];
  endfunction

  task automatic complete_run;
    if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      errors++;
      complete_run();
    end
  endtask

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    chk("hresp", 32'(hresp), 32'h0);
  endtask

  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    base = 4'h0;
    cfg = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("accepted idle", 32'(dao), 32'h1);
    for (int i = 0; i < 4; i++) begin
      base <= 4'(rnd());
      cfg <= rnd();
      @(posedge clk);
      for (int k = 0; k < 4; k++) begin
        bus(1'b0, adr(3'(4 + k)), 32'h0, d);
        chk("switch", d, {28'h0, cfg.fmt[k], cfg.c[k], cfg.b[k], cfg.a[k]});
      end
      bus(1'b0, adr(3'h3), 32'h0, d);
      chk("channel", 32'(d[24:16]), 32'(9'h101 + base));
      bus(1'b0, adr(3'h3) ^ 32'h20, 32'h0, d);
      chk("other window", d, 32'h0);
    end
    for (int i = 0; i < 6; i++) begin
      f = i == 1 ? 4'h9 : i < 3 ? 4'h8 : 4'(i - 3);
      w = rnd();
      if (i < 2) w[15] = 1'b1;
      if (i == 2) w[15] = 1'b0;
      if (i > 2) w &= 16'h7777;
      if (i == 3) w = 16'h1234;
      cfg.fmt <= f;
      src.present(w);
      repeat (2) @(posedge clk);
      bus(1'b0, adr(3'h0), 32'h0, d);
      chk("low byte", d, {24'h0, w[7:0]});
      bus(1'b0, adr(3'h2), 32'h0, d);
      chk("decoded", d, dec(w, f));
      chk("accepted early", 32'(dao), 32'h1);
      bus(1'b0, adr(3'h1), 32'h0, d);
      chk("high byte", d, {24'h0, w[15:8]});
      src.finish(i, ok);
      chk("accepted", 32'(ok), 32'h1);
      chk("accepted back", 32'(dao), 32'h1);
    end
    // acknowledge on capture so the buffer can fill
    bus(1'b1, adr(3'h3), 32'h1, d);
    for (int i = 0; i < 17; i++) begin
      w = rnd();
      if (i < 16) wq[i] = w;
      src.present(w);
      src.finish(0, ok);
      chk("taken", 32'(ok), 32'(i < 16));
    end
    bus(1'b0, adr(3'h3), 32'h0, d);
    chk("full status", 32'(d[7:0]), 32'h85);
    for (int i = 0; i < 16; i++) begin
      bus(1'b0, adr(3'h0), 32'h0, d);
      chk("drain low", d, {24'h0, wq[i][7:0]});
      bus(1'b0, adr(3'h1), 32'h0, d);
      chk("drain high", d, {24'h0, wq[i][15:8]});
    end
    bus(1'b0, adr(3'h1), 32'h0, d);
    chk("empty read", d, 32'h0);
    // source with accepted tied to valid; early ack is still set, so words keep flowing
    w = rnd();
    src.tied(w, 8);
    bus(1'b0, adr(3'h3), 32'h0, d);
    chk("tied level", 32'(d[7:3] != 5'h0), 32'h1);
    bus(1'b0, adr(3'h0), 32'h0, d);
    chk("tied low", d, {24'h0, w[7:0]});
    bus(1'b0, adr(3'h1), 32'h0, d);
    chk("tied high", d, {24'h0, w[15:8]});
    chk("tied accepted", 32'(dao), 32'h1);
    complete_run();
  end
endmodule
